/* logic/stamp_pkg.sv */
// Purpose: shared constants and carriers of the seconds referenced timestamp counter
// Assumes: register numbers are used as plain indexes on the register port
// Notes: codes and offsets are the software visible values
package stamp_pkg;

  // register numbers as software writes them
  localparam logic [15:0] stamp_command_and_mode_addr = 16'hB798;
  localparam logic [15:0] stamp_buffer_fill_state_addr = 16'hB7A2;
  localparam logic [15:0] absolute_start_seconds_addr = 16'hB7B6;
  localparam logic [15:0] stamp_buffer_read_port_addr = 16'hB7C0;
  localparam logic [15:0] seconds_edge_select_addr = 16'hB7CA;

  // command and mode codes
  localparam logic [31:0] counter_clear_cmd = 32'h0000_0000;
  localparam logic [31:0] stamping_off_cmd = 32'h0000_000A;
  localparam logic [31:0] seconds_referenced_mode = 32'h0000_000D;
  localparam logic [31:0] mode_reset_value = 32'h0000_000A;

  // seconds edge selection
  localparam logic [31:0] seconds_rising_edge = 32'h0000_000A;
  localparam logic [31:0] seconds_falling_edge = 32'h0000_0014;
  localparam logic [31:0] edge_reset_value = 32'h0000_000A;

  // buffer fill states
  localparam logic [1:0] buffer_empty_state = 2'h0;
  localparam logic [1:0] buffer_below_half_state = 2'h1;
  localparam logic [1:0] buffer_above_half_state = 2'h2;
  localparam logic [1:0] buffer_overrun_state = 2'h3;

  // counter and buffer geometry
  localparam int sample_bits = 32;
  localparam int seconds_bits = 24;
  localparam int entry_bits = 64;
  localparam int store_depth = 65536;
  localparam int store_addr_bits = 16;
  localparam int stage_depth = 4;
  localparam logic [16:0] store_half = 17'h0_8000;
  localparam logic [16:0] store_full = 17'h1_0000;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } reg_rsp_t;

endpackage : stamp_pkg

/* logic/stamp_counter.sv */
// Purpose: wide timestamp counter referenced to an external seconds pulse, with stamp buffer
// Assumes: trig_event and the register port are on clk_sys; seconds_pulse is a raw pin
// Notes: a small staging fifo decouples capture from the large stamp store
//
// How it works
// - counter splits into seconds and samples parts
// - upper part counts seconds since the aligning pulse edge that follows a clear command
// - lower part clears on pulse, else counts once aligned
// - clear command zeroes, then aligns to pulse
// - stamping off command stops trigger capture
// - command write executes, read returns mode
// - edge select 10 rising, 20 falling
// - edge select sets the pulse edge for both parts and alignment
// - start time register gives epoch seconds
// - status reports empty, below, above half
// - status 3 when buffer overran
// - each trigger cycle in referenced mode copies counter into buffer, unless the staging fifo is full
// - buffer holds 64K stamps, readable anytime
// - 56-bit stamp, samples word then seconds
// - read port gives next word or zero
`timescale 1ns/1ns

module stamp_fifo #(
  parameter int width = 64,
  parameter int depth = 4
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [width-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [width-1:0] out_data
);
  localparam int ptr_bits = $clog2(depth);

  typedef struct packed {
    logic [depth-1:0][width-1:0] mem;
    logic [ptr_bits-1:0] head;
    logic [ptr_bits-1:0] tail;
    logic [ptr_bits:0] count;
  } fifo_state_t;

  fifo_state_t state;
  fifo_state_t next_state;
  logic push;
  logic pop;

  always_comb begin
    next_state = state;
    push = in_valid && (state.count != depth[ptr_bits:0]);
    pop = out_ready && (state.count != '0);
    if (push) begin
      next_state.mem[state.tail] = in_data;
      next_state.tail = state.tail + 1'b1;
    end
    if (pop) begin
      next_state.head = state.head + 1'b1;
    end
    next_state.count = state.count + {{ptr_bits{1'b0}}, push} - {{ptr_bits{1'b0}}, pop};
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign in_ready = (state.count != depth[ptr_bits:0]);
  assign out_valid = (state.count != '0);
  assign out_data = state.mem[state.head];
endmodule : stamp_fifo

module stamp_counter
  import stamp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire stamp_pkg::reg_req_t reg_req,
  output stamp_pkg::reg_rsp_t reg_rsp,
  input wire logic seconds_pulse,
  input wire logic trig_event,
  input wire logic [31:0] epoch_seconds,
  output logic aligning,
  output logic [stamp_pkg::sample_bits-1:0] sample_count,
  output logic [stamp_pkg::seconds_bits-1:0] seconds_count
);
  import stamp_pkg::*;

  typedef struct packed {
    logic pulse_meta;
    logic pulse_sync;
    logic pulse_prev;
    logic [31:0] mode;
    logic [31:0] edge_sel;
    logic [31:0] start_seconds;
    logic waiting;
    logic [sample_bits-1:0] lo;
    logic [seconds_bits-1:0] hi;
    logic [store_addr_bits-1:0] rd_ptr;
    logic [store_addr_bits-1:0] wr_ptr;
    logic [16:0] fill;
    logic high_word;
    logic overrun;
    reg_rsp_t rsp;
  } core_state_t;

  core_state_t state;
  core_state_t next_state;
  logic [entry_bits-1:0] store [store_depth];
  logic [entry_bits-1:0] head_entry;
  logic pulse_edge;
  logic clear_cmd;
  logic capture;
  logic stage_in_ready;
  logic stage_out_valid;
  logic [entry_bits-1:0] stage_out_data;
  logic store_push;
  logic store_pop;
  logic store_empty;

  // only the second flop and its delayed copy feed the edge detector
  always_comb begin
    if (state.edge_sel == seconds_falling_edge) begin
      pulse_edge = state.pulse_prev && !state.pulse_sync;
    end else begin
      pulse_edge = state.pulse_sync && !state.pulse_prev;
    end
  end

  assign clear_cmd = reg_req.wr && (reg_req.addr == stamp_command_and_mode_addr)
    && (reg_req.wdata == counter_clear_cmd);
  assign capture = trig_event && (state.mode == seconds_referenced_mode);
  assign store_empty = (state.fill == 17'h0_0000);
  assign store_push = stage_out_valid && (state.fill != store_full);
  assign store_pop = reg_req.rd && (reg_req.addr == stamp_buffer_read_port_addr)
    && !store_empty && state.high_word;
  assign head_entry = store[state.rd_ptr];

  stamp_fifo #(
    .width(entry_bits),
    .depth(stage_depth)
  ) u_stage (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(capture),
    .in_ready(stage_in_ready),
    .in_data({{(entry_bits - sample_bits - seconds_bits){1'b0}}, state.hi, state.lo}),
    .out_valid(stage_out_valid),
    .out_ready(store_push),
    .out_data(stage_out_data)
  );

  always_comb begin
    next_state = state;
    next_state.pulse_meta = seconds_pulse;
    next_state.pulse_sync = state.pulse_meta;
    next_state.pulse_prev = state.pulse_sync;

    // counter: clear command wins, then the seconds edge, then sample counting
    if (clear_cmd) begin
      next_state.lo = '0;
      next_state.hi = '0;
      next_state.waiting = 1'b1;
    end else if (pulse_edge) begin
      next_state.lo = '0;
      if (state.waiting) begin
        next_state.waiting = 1'b0;
        next_state.hi = '0;
        next_state.start_seconds = epoch_seconds;
      end else begin
        next_state.hi = state.hi + 1'b1;
      end
    end else if (!state.waiting) begin
      next_state.lo = state.lo + 1'b1;
    end

    // mode codes; entering the referenced mode leaves the counter alone
    if (reg_req.wr && (reg_req.addr == stamp_command_and_mode_addr)) begin
      if (reg_req.wdata == stamping_off_cmd || reg_req.wdata == seconds_referenced_mode) begin
        next_state.mode = reg_req.wdata;
      end
    end
    if (reg_req.wr && (reg_req.addr == seconds_edge_select_addr)) begin
      next_state.edge_sel = reg_req.wdata;
    end

    // a trigger that finds the staging fifo full is lost and flagged for good
    if (capture && !stage_in_ready) begin
      next_state.overrun = 1'b1;
    end

    if (store_push) begin
      next_state.wr_ptr = state.wr_ptr + 1'b1;
    end
    if (store_pop) begin
      next_state.rd_ptr = state.rd_ptr + 1'b1;
    end
    next_state.fill = state.fill + {16'h0000, store_push} - {16'h0000, store_pop};

    next_state.rsp.valid = reg_req.rd;
    next_state.rsp.data = '0;
    if (reg_req.rd) begin
      case (reg_req.addr)
        stamp_command_and_mode_addr: next_state.rsp.data = state.mode;
        seconds_edge_select_addr: next_state.rsp.data = state.edge_sel;
        absolute_start_seconds_addr: next_state.rsp.data = state.start_seconds;
        stamp_buffer_fill_state_addr: begin
          if (state.overrun) begin
            next_state.rsp.data = {30'h0000_0000, buffer_overrun_state};
          end else if (store_empty) begin
            next_state.rsp.data = {30'h0000_0000, buffer_empty_state};
          end else if (state.fill > store_half) begin
            next_state.rsp.data = {30'h0000_0000, buffer_above_half_state};
          end else begin
            next_state.rsp.data = {30'h0000_0000, buffer_below_half_state};
          end
        end
        stamp_buffer_read_port_addr: begin
          if (!store_empty) begin
            // samples word first, seconds word second, then the entry is retired
            next_state.rsp.data = state.high_word ? head_entry[63:32] : head_entry[31:0];
            next_state.high_word = !state.high_word;
          end
        end
        default: next_state.rsp.data = '0;
      endcase
    end
  end

  // the store is kept out of the reset state vector; only pointers need a reset
  always_ff @(posedge clk_sys) begin
    if (store_push) begin
      store[state.wr_ptr] <= stage_out_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
      state.mode <= mode_reset_value;
      state.edge_sel <= edge_reset_value;
      state.waiting <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rsp = state.rsp;
  assign aligning = state.waiting;
  assign sample_count = state.lo;
  assign seconds_count = state.hi;
endmodule : stamp_counter

/* dv/stamp_counter_monitor.sv */
// Purpose: port checker of the seconds referenced stamp counter
// Assumes: one clock domain, asynchronous active low reset
// Notes: a pin age counter stands in for the internal synchroniser
`timescale 1ns/1ns
module stamp_counter_monitor
  import stamp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire stamp_pkg::reg_req_t reg_req,
  input wire stamp_pkg::reg_rsp_t reg_rsp,
  input wire logic seconds_pulse,
  input wire logic trig_event,
  input wire logic [31:0] epoch_seconds,
  input wire logic aligning,
  input wire logic [stamp_pkg::sample_bits-1:0] sample_count,
  input wire logic [stamp_pkg::seconds_bits-1:0] seconds_count
);
  logic prev_pin;
  logic [3:0] since;
  wire logic clr = reg_req.wr && reg_req.addr == stamp_command_and_mode_addr
    && reg_req.wdata == counter_clear_cmd;
  // saturating age of the last pin change, so an edge can be tied to its cause
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prev_pin <= 1'b0;
      since <= 4'hF;
    end else begin
      prev_pin <= seconds_pulse;
      since <= (seconds_pulse != prev_pin) ? 4'h0 : (since == 4'hF ? since : since + 4'h1);
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_ans; reg_req.rd |=> reg_rsp.valid; endproperty
  a_ans: assert property (p_ans) else $error("read got no answer");
  property p_quiet; !reg_req.rd |=> !reg_rsp.valid && reg_rsp.data == 32'h0; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without read");
  property p_clr; clr |=> aligning && sample_count == 32'h0 && seconds_count == 24'h0; endproperty
  a_clr: assert property (p_clr) else $error("clear did not zero");
  property p_hold; aligning |-> sample_count == 32'h0 && seconds_count == 24'h0; endproperty
  a_hold: assert property (p_hold) else $error("count moved while aligning");
  property p_lower;
    !aligning && sample_count != 32'h0 |-> sample_count == $past(sample_count) + 32'h1;
  endproperty
  a_lower: assert property (p_lower) else $error("lower part skipped");
  property p_upper;
    $changed(seconds_count) |-> seconds_count == 24'h0 || seconds_count == $past(seconds_count) + 24'h1;
  endproperty
  a_upper: assert property (p_upper) else $error("upper part jumped");
  property p_both; $changed(seconds_count) && seconds_count != 24'h0 |-> sample_count == 32'h0; endproperty
  a_both: assert property (p_both) else $error("parts stepped apart");
  property p_sync;
    ($fell(aligning) || (sample_count == 32'h0 && $past(sample_count) != 32'h0 && !$past(clr)))
      |-> since >= 4'h2 && since <= 4'h5;
  endproperty
  a_sync: assert property (p_sync) else $error("edge acted at wrong delay");
  c_clear: cover property (clr);
  c_align: cover property ($fell(aligning));
  c_data: cover property (reg_rsp.valid && reg_rsp.data != 32'h0);
endmodule : stamp_counter_monitor
bind stamp_counter stamp_counter_monitor stamp_counter_monitor_inst (.clk_sys, .rst_n, .reg_req,
  .reg_rsp, .seconds_pulse, .trig_event, .epoch_seconds, .aligning, .sample_count, .seconds_count);

/* dv/seconds_source.sv */
// Purpose: model of the outside seconds reference
// Assumes: one start per simulated second
// Notes: a second is squeezed into a few dozen cycles to keep the run short
`timescale 1ns/1ns
module seconds_source #(
  parameter int high_len = 20
) (
  input wire logic clk_sys,
  input wire logic start,
  output logic seconds_pulse
);
  int left = 0;
  always_ff @(posedge clk_sys) begin
    if (start) left <= high_len;
    else if (left > 0) left <= left - 1;
  end
  assign seconds_pulse = (left > 0);
endmodule : seconds_source

/* dv/stamp_counter_bench.sv */
// Purpose: self-checking bench of the seconds referenced stamp counter
// Assumes: inputs change at the falling edge
// Notes: the overrun pass needs some 65545 triggers, so it runs last
`timescale 1ns/1ns
module stamp_counter_bench;
  import stamp_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  reg_req_t reg_req = '0;
  reg_rsp_t reg_rsp;
  logic start = 1'b0;
  logic trig_event = 1'b0;
  logic seconds_pulse, aligning;
  logic [31:0] epoch_seconds = 32'h0, ep, rv, seed = 32'h0000_0B88;
  logic [sample_bits-1:0] sample_count;
  logic [seconds_bits-1:0] seconds_count;
  int failures = 0, comparisons = 0, cyc = 0, k;
  always #4 clk_sys = ~clk_sys;
  stamp_counter stamp_counter_inst (.clk_sys, .rst_n, .reg_req, .reg_rsp, .seconds_pulse,
    .trig_event, .epoch_seconds, .aligning, .sample_count, .seconds_count);
  seconds_source seconds_source_inst (.clk_sys, .start, .seconds_pulse);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [31:0] fill_state(int n);
    if (n == 0) return 32'h0;
    return (n > 32768) ? 32'h2 : 32'h1;
  endfunction : fill_state
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(logic [15:0] a, logic [31:0] d);
    @(negedge clk_sys);
    reg_req <= '{1'b1, 1'b0, a, d};
    @(negedge clk_sys);
    reg_req <= '0;
  endtask : wr
  task automatic rchk(logic [15:0] a, logic [31:0] exp);
    @(negedge clk_sys);
    reg_req <= '{1'b0, 1'b1, a, 32'h0};
    @(negedge clk_sys);
    rv = (reg_rsp.valid === 1'b1) ? reg_rsp.data : 32'hDEAD_BEEF;
    reg_req <= '0;
    chk(rv, exp);
  endtask : rchk
  // called at a falling edge: n rising edges see the trigger high
  task automatic burst(int n);
    trig_event <= 1'b1;
    repeat (n) @(negedge clk_sys);
    trig_event <= 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask : burst
  task automatic pulse();
    @(negedge clk_sys);
    start <= 1'b1;
    @(negedge clk_sys);
    start <= 1'b0;
  endtask : pulse
  task automatic print_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 90000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    repeat (8) @(negedge clk_sys);
    rst_n <= 1'b1;
    rchk(stamp_command_and_mode_addr, mode_reset_value);
    rchk(seconds_edge_select_addr, edge_reset_value);
    rchk(stamp_buffer_fill_state_addr, 32'h0);
    rchk(stamp_buffer_read_port_addr, 32'h0);
    rchk(16'h1234, 32'h0);
    $display("test reset done");
    wr(stamp_command_and_mode_addr, seconds_referenced_mode);
    wr(seconds_edge_select_addr, seconds_falling_edge);
    rchk(stamp_command_and_mode_addr, seconds_referenced_mode);
    rchk(seconds_edge_select_addr, seconds_falling_edge);
    wr(stamp_command_and_mode_addr, counter_clear_cmd);
    chk({31'h0, aligning}, 32'h1);
    ep = rnd();
    epoch_seconds <= ep;
    pulse();
    repeat (12) @(negedge clk_sys);
    chk({31'h0, aligning}, 32'h1);
    for (int i = 0; i < 200 && aligning !== 1'b0; i++) @(negedge clk_sys);
    chk({31'h0, aligning}, 32'h0);
    k = 1 + int'(rnd() & 32'hF);
    repeat (k) @(negedge clk_sys);
    burst(1);
    epoch_seconds <= rnd();
    rchk(stamp_buffer_fill_state_addr, fill_state(1));
    rchk(stamp_buffer_read_port_addr, k);
    rchk(stamp_buffer_read_port_addr, 32'h0);
    rchk(stamp_buffer_fill_state_addr, fill_state(0));
    wr(absolute_start_seconds_addr, ~ep);
    rchk(absolute_start_seconds_addr, ep);
    $display("test align done");
    wr(seconds_edge_select_addr, seconds_rising_edge);
    pulse();
    for (int i = 0; i < 50 && sample_count !== 32'h0; i++) @(negedge clk_sys);
    k = 24 + int'(rnd() & 32'hF);
    repeat (k) @(negedge clk_sys);
    burst(1);
    wr(stamp_command_and_mode_addr, stamping_off_cmd);
    burst(1);
    rchk(stamp_command_and_mode_addr, stamping_off_cmd);
    rchk(stamp_buffer_fill_state_addr, fill_state(1));
    rchk(stamp_buffer_read_port_addr, k);
    rchk(stamp_buffer_read_port_addr, 32'h1);
    rchk(stamp_buffer_fill_state_addr, fill_state(0));
    $display("test seconds done");
    wr(stamp_command_and_mode_addr, seconds_referenced_mode);
    @(negedge clk_sys);
    // the oldest entry of this pass is the one the read port must show after overrun
    k = int'(sample_count);
    burst(32768);
    rchk(stamp_buffer_fill_state_addr, fill_state(32768));
    burst(1);
    rchk(stamp_buffer_fill_state_addr, fill_state(32769));
    burst(32776);
    rchk(stamp_buffer_fill_state_addr, 32'h3);
    rchk(stamp_buffer_read_port_addr, k);
    rchk(stamp_buffer_fill_state_addr, 32'h3);
    $display("test fill done");
    print_verdict();
  end
endmodule : stamp_counter_bench
